// ==== hdl/adcp_defines.vh ====
/*
 * Constants for the serial conversion port of the eight-channel 12-bit converter.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef ADCP_DEFINES_VH
`define ADCP_DEFINES_VH

// Configuration register layout and power-up value
`define ADCP_CFG_BITS 8
`define ADCP_CFG_RESET 8'h00
`define ADCP_CFG_CNT_W 4
`define ADCP_CFG_LAST 4'h7
`define ADCP_CFG_FULL 4'h8
`define ADCP_CH_MSB 5
`define ADCP_CH_LSB 3
`define ADCP_CH_RESET 3'h0
`define ADCP_REF_BIT 2
`define ADCP_PM_MSB 1
`define ADCP_PM_LSB 0

// Result frame: leading zeros then the code, most significant bit first
`define ADCP_CODE_BITS 12
`define ADCP_FRAME_BITS 16
`define ADCP_LEAD_ZEROS 4'h0

// Frame timing in serial clock half periods: 29 to end the conversion, 32 for the whole frame
`define ADCP_HALF_W 6
`define ADCP_CONV_HALVES 6'h1d
`define ADCP_FRAME_HALVES 6'h20

// Result buffer
`define ADCP_FIFO_DEPTH 16
`define ADCP_FIFO_AW 4

`endif

// ==== hdl/adcp_serial_port.v ====
/*
 * Serial control and conversion sequencing of an eight-channel 12-bit converter,
 * with the result buffer that feeds its output frames.
 * Assumes the serial pins arrive asynchronously and are oversampled by ref_clk,
 * which must run well above twice the serial clock; the analog core sits outside
 * and answers each conversion start with one code over the result handshake.
 */
// Functional notes
// - A conversion frame lasts 16 serial clock periods, 14.5 converting then 1.5 acquiring.
// - A falling chip select starts a conversion.
// - Chip select frames the transfer and nothing shifts while it is high.
// - After chip select falls the result output is driven.
// - When chip select rises the result output is released.
// - The configuration input is sampled on each of the first eight serial clock rising edges of a frame.
// - The result output changes on each serial clock falling edge.
// - A result frame is four zeros and then the 12-bit code, most significant bit first.
// - The serial clock is the only timing source for conversion and transfer.
// - A three-bit channel field of the configuration selects one of eight inputs.
// - Only the first eight rising edges of a frame load the configuration, MSB first.
// - A new channel address takes effect at the end of the current conversion.
// - The configuration register is all zeros after reset.

`default_nettype none

`include "adcp_defines.vh"

module adcp_fifo #(
	parameter WIDTH = `ADCP_CODE_BITS,
	parameter DEPTH = `ADCP_FIFO_DEPTH,
	parameter AW = `ADCP_FIFO_AW
) (
	// Clock and reset
	input wire ref_clk,
	input wire srst,
	// Fill side
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	// Drain side
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_q;
	reg [AW-1:0] rdPtr_q;
	reg [AW:0] count_q;
	wire doPush;
	wire doPop;

	// Pointer step, wrapping at the depth, which is a power of two
	function [AW-1:0] ptrStep;
		input [AW-1:0] ptr;
		begin
			ptrStep = ptr + {{(AW-1){1'b0}}, 1'b1};
		end
	endfunction

	// Fill level one up or one down
	function [AW:0] levelStep;
		input [AW:0] level;
		input up;
		begin
			if (up) begin
				levelStep = level + {{AW{1'b0}}, 1'b1};
			end else begin
				levelStep = level - {{AW{1'b0}}, 1'b1};
			end
		end
	endfunction

	// The level reaches the depth only when full, so its top bit alone marks it
	assign inReady = ~count_q[AW];
	assign outValid = (count_q != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_q];
	assign doPush = inValid & inReady;
	assign doPop = outValid & outReady;

	always @(posedge ref_clk) begin
		if (doPush) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (doPush) begin
				wrPtr_q <= ptrStep(wrPtr_q);
			end
			if (doPop) begin
				rdPtr_q <= ptrStep(rdPtr_q);
			end
			// Simultaneous push and pop leave the fill level unchanged
			if (doPush & ~doPop) begin
				count_q <= levelStep(count_q, 1'b1);
			end else if (doPop & ~doPush) begin
				count_q <= levelStep(count_q, 1'b0);
			end
		end
	end
endmodule // adcp_fifo

module adcp_serial_port (
	// Clock and reset
	input wire ref_clk,
	input wire srst,
	// Serial pins from the host
	input wire csN,
	input wire sclk,
	input wire din,
	// Serial result pin, two signals of a tri-state output
	output wire dout,
	output wire doutOe,
	// Conversion control towards the analog core
	output wire convStart,
	output wire convEnd,
	output wire holdActive,
	output wire acqActive,
	output wire [2:0] channelAddressField,
	// Configuration fields towards reference and power management
	output wire refDisable,
	output wire [1:0] powerMode,
	// Conversion results from the analog core
	input wire resValid,
	output wire resReady,
	input wire [`ADCP_CODE_BITS-1:0] resData
);
	// Pin synchronisers; only the second stage and later are read by logic
	reg csNS1_q;
	reg csNS2_q;
	reg csNS3_q;
	reg sclkS1_q;
	reg sclkS2_q;
	reg sclkS3_q;
	reg dinS1_q;
	reg dinS2_q;

	reg [`ADCP_HALF_W-1:0] halfCnt_q;
	reg [`ADCP_CFG_CNT_W-1:0] cfgCnt_q;
	reg [`ADCP_CFG_BITS-1:0] cfgShift_q;
	reg [`ADCP_CFG_BITS-1:0] cfg_q;
	reg [2:0] channel_q;
	reg [`ADCP_FRAME_BITS-1:0] outShift_q;
	reg convStart_q;
	reg convEnd_q;
	reg hold_q;
	reg acq_q;

	wire csActive;
	wire csFall;
	wire sclkRise;
	wire sclkFall;
	wire [`ADCP_HALF_W-1:0] halfNext;
	wire [`ADCP_CFG_BITS-1:0] cfgNext;
	wire fifoValid;
	wire [`ADCP_CODE_BITS-1:0] fifoData;

	// Edge of a synchronised level, from its newer and older samples
	function wentHigh;
		input newer;
		input older;
		begin
			wentHigh = newer & ~older;
		end
	endfunction

	assign csActive = ~csNS2_q;
	assign csFall = wentHigh(~csNS2_q, ~csNS3_q);
	// The serial clock is the only time base for the frame
	assign sclkRise = csActive & wentHigh(sclkS2_q, sclkS3_q);
	assign sclkFall = csActive & wentHigh(~sclkS2_q, ~sclkS3_q);
	assign halfNext = halfCnt_q + {{(`ADCP_HALF_W-1){1'b0}}, 1'b1};
	assign cfgNext = {cfgShift_q[`ADCP_CFG_BITS-2:0], dinS2_q};

	always @(posedge ref_clk) begin
		if (srst) begin
			csNS1_q <= 1'b1;
			csNS2_q <= 1'b1;
			csNS3_q <= 1'b1;
			sclkS1_q <= 1'b0;
			sclkS2_q <= 1'b0;
			sclkS3_q <= 1'b0;
			dinS1_q <= 1'b0;
			dinS2_q <= 1'b0;
		end else begin
			csNS1_q <= csN;
			csNS2_q <= csNS1_q;
			csNS3_q <= csNS2_q;
			sclkS1_q <= sclk;
			sclkS2_q <= sclkS1_q;
			sclkS3_q <= sclkS2_q;
			dinS1_q <= din;
			dinS2_q <= dinS1_q;
		end
	end

	// Frame sequencing: half periods counted on both serial clock edges
	always @(posedge ref_clk) begin
		if (srst) begin
			halfCnt_q <= {`ADCP_HALF_W{1'b0}};
			hold_q <= 1'b0;
			acq_q <= 1'b0;
			convStart_q <= 1'b0;
			convEnd_q <= 1'b0;
			channel_q <= `ADCP_CH_RESET;
		end else begin
			convStart_q <= 1'b0;
			convEnd_q <= 1'b0;
			if (csFall) begin
				halfCnt_q <= {`ADCP_HALF_W{1'b0}};
				hold_q <= 1'b1;
				acq_q <= 1'b0;
				convStart_q <= 1'b1;
			end else if (!csActive) begin
				// A frame cut short ends its conversion with the frame itself
				halfCnt_q <= {`ADCP_HALF_W{1'b0}};
				hold_q <= 1'b0;
				acq_q <= 1'b0;
			end else if ((sclkRise | sclkFall) && halfCnt_q != `ADCP_FRAME_HALVES) begin
				// Edges past the last half period wait for chip select to rise
				halfCnt_q <= halfNext;
				if (halfNext == `ADCP_CONV_HALVES) begin
					hold_q <= 1'b0;
					acq_q <= 1'b1;
					convEnd_q <= 1'b1;
					// Channel swaps only between conversions, never mid-hold
					channel_q <= cfg_q[`ADCP_CH_MSB:`ADCP_CH_LSB];
				end else if (halfNext == `ADCP_FRAME_HALVES) begin
					acq_q <= 1'b0;
				end
			end
		end
	end

	// Configuration loading on rising edges
	always @(posedge ref_clk) begin
		if (srst) begin
			cfgCnt_q <= {`ADCP_CFG_CNT_W{1'b0}};
			cfgShift_q <= `ADCP_CFG_RESET;
			cfg_q <= `ADCP_CFG_RESET;
		end else if (csFall) begin
			cfgCnt_q <= {`ADCP_CFG_CNT_W{1'b0}};
		end else if (sclkRise && cfgCnt_q != `ADCP_CFG_FULL) begin
			cfgShift_q <= cfgNext;
			cfgCnt_q <= cfgCnt_q + {{(`ADCP_CFG_CNT_W-1){1'b0}}, 1'b1};
			// Committed whole, so a short frame leaves the old setting intact
			if (cfgCnt_q == `ADCP_CFG_LAST) begin
				cfg_q <= cfgNext;
			end
		end
	end

	// Result shifting on falling edges
	always @(posedge ref_clk) begin
		if (srst) begin
			outShift_q <= {`ADCP_FRAME_BITS{1'b0}};
		end else if (csFall) begin
			// An empty buffer yields an all-zero frame rather than stale data
			if (fifoValid) begin
				outShift_q <= {`ADCP_LEAD_ZEROS, fifoData};
			end else begin
				outShift_q <= {`ADCP_FRAME_BITS{1'b0}};
			end
		end else if (!csActive) begin
			// Idle clear, so a cut frame never shows a stale bit when the line opens
			outShift_q <= {`ADCP_FRAME_BITS{1'b0}};
		end else if (sclkFall) begin
			outShift_q <= {outShift_q[`ADCP_FRAME_BITS-2:0], 1'b0};
		end
	end

	// Popped at frame open, so each frame carries the oldest buffered code
	adcp_fifo #(
		.WIDTH(`ADCP_CODE_BITS),
		.DEPTH(`ADCP_FIFO_DEPTH),
		.AW(`ADCP_FIFO_AW)
	) resultFifo (
		.ref_clk(ref_clk),
		.srst(srst),
		.inValid(resValid),
		.inReady(resReady),
		.inData(resData),
		.outValid(fifoValid),
		.outReady(csFall),
		.outData(fifoData)
	);

	assign dout = outShift_q[`ADCP_FRAME_BITS-1];
	assign doutOe = csActive;
	assign convStart = convStart_q;
	assign convEnd = convEnd_q;
	assign holdActive = hold_q;
	assign acqActive = acq_q;
	assign channelAddressField = channel_q;
	assign refDisable = cfg_q[`ADCP_REF_BIT];
	assign powerMode = cfg_q[`ADCP_PM_MSB:`ADCP_PM_LSB];
endmodule // adcp_serial_port

`default_nettype wire

// ==== dv/adcp_serial_port_properties.sv ====
/* Checker of the serial pins and conversion controls of adcp_serial_port.
   Assumes host clock phases of five ref_clk cycles. */
`default_nettype none
module adcp_serial_port_properties (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Serial pins
	input wire logic csN,
	input wire logic sclk,
	input wire logic dout,
	input wire logic doutOe,
	// Controls
	input wire logic convStart,
	input wire logic convEnd,
	input wire logic holdActive,
	input wire logic acqActive,
	input wire logic [2:0] channelAddressField,
	input wire logic refDisable,
	input wire logic [1:0] powerMode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic sclkPrev_q;
	logic [4:0] riseCnt_q;
	// Pin-level count of serial clock rises in the current frame
	always @(posedge ref_clk) begin
		sclkPrev_q <= sclk;
		if (srst || csN) begin
			riseCnt_q <= 5'h00;
		end else if (sclk && !sclkPrev_q) begin
			riseCnt_q <= riseCnt_q + 5'h01;
		end
	end
	a_end_at_rise:
		assert property (convEnd |-> riseCnt_q == 5'h0f) else $error("end off count");
	a_acq_close:
		assert property ($fell(acqActive) && doutOe |-> riseCnt_q == 5'h10) else $error("acq count");
	sequence s_open;
		doutOe && convStart && holdActive && !dout;
	endsequence
	a_frame_open:
		assert property ($fell(csN) |-> ##[2:5] s_open) else $error("frame not opened");
	a_line_release:
		assert property ($rose(csN) |-> ##[2:5] !doutOe) else $error("line kept");
	a_conv_end:
		assert property (convEnd |-> acqActive && !holdActive) else $error("bad end");
	a_start_once:
		assert property (convStart |=> !convStart && holdActive) else $error("bad start");
	a_chan_at_end:
		assert property ($changed(channelAddressField) |-> convEnd) else $error("early chan");
	a_cfg_in_frame:
		assert property ($changed({refDisable, powerMode}) |-> doutOe) else $error("cfg idle");
	a_dout_on_fall:
		assert property (doutOe && $past(doutOe) && $changed(dout) |-> !sclk) else $error("shift");
	a_hold_to_acq:
		assert property ($fell(holdActive) |-> acqActive || !doutOe) else $error("no acq");
endmodule // adcp_serial_port_properties
bind adcp_serial_port adcp_serial_port_properties u_props (.*);
`default_nettype wire

// ==== dv/adcp_host_model.sv ====
/* Host serial controller model: chip select, clock and configuration.
   Assumes ref_clk as time base; the caller enters at a falling edge. */
`default_nettype none
module adcp_host_model (
	// Time base
	input wire logic ref_clk,
	// Result line
	input wire logic dout,
	input wire logic doutOe,
	// Host pins
	output var logic csN,
	output var logic sclk,
	output var logic din
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 5;
	// About 5 us of ref_clk before a result after a wake-up is trusted
	localparam int WAKE = 250;
	task automatic wake;
		repeat (WAKE) @(negedge ref_clk);
	endtask
	logic lastBit = 1'h0;
	// A released line must not look like a held bit
	wire logic line = doutOe ? dout : ~lastBit;
	always @(posedge ref_clk) if (doutOe) lastBit <= dout;
	initial begin
		csN = 1'h1;
		sclk = 1'h0;
		din = 1'h0;
	end
	task automatic frame(input logic [7:0] cfg, input int rises, output logic [15:0] rx);
		rx = 16'h0000;
		csN = 1'h0;
		for (int i = 0; i < rises; i++) begin
			din = (i < 8) ? cfg[7 - i] : ~cfg[i - 8];
			repeat (HALF) @(negedge ref_clk);
			sclk = 1'h1;
			rx = {rx[14:0], line};
			repeat (HALF) @(negedge ref_clk);
			sclk = 1'h0;
		end
		repeat (HALF) @(negedge ref_clk);
		csN = 1'h1;
		repeat (HALF) @(negedge ref_clk);
	endtask
endmodule // adcp_host_model
`default_nettype wire

// ==== dv/testbench.sv ====
/* Self-checking bench of the serial conversion port.
   Assumes the host model on the pins; the bench plays the analog core. */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'h0, srst = 1'h1, resValid = 1'h0;
	logic [11:0] resData = 12'h000;
	logic [15:0] rx;
	logic [7:0] cfg;
	wire logic csN, sclk, din, dout, doutOe, resReady, refDisable;
	wire logic [2:0] chan;
	wire logic [1:0] pm;
	int nMismatch = 0, samplesChecked = 0;
	always #10 ref_clk = ~ref_clk;
	adcp_serial_port dut (.ref_clk(ref_clk), .srst(srst), .csN(csN), .sclk(sclk), .din(din),
		.dout(dout), .doutOe(doutOe), .convStart(), .convEnd(), .holdActive(), .acqActive(),
		.channelAddressField(chan), .refDisable(refDisable), .powerMode(pm),
		.resValid(resValid), .resReady(resReady), .resData(resData));
	adcp_host_model host (.ref_clk(ref_clk), .dout(dout), .doutOe(doutOe), .csN(csN),
		.sclk(sclk), .din(din));
	task check(input logic [15:0] seen, input logic [15:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		if (nMismatch == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	function logic [11:0] code(input int k);
		return 12'hf0f ^ 12'(k * 291);
	endfunction
	task t_reset;
		repeat (6) @(negedge ref_clk);
		srst = 1'h0;
		repeat (3) @(negedge ref_clk);
		check({chan, refDisable, pm, resReady}, 16'h0001);
	endtask
	task t_channels;
		for (int k = 0; k < 8; k++) begin
			cfg = {k[0], 1'h0, k[2:0], k[1], k[1:0]};
			host.frame(cfg, 16, rx);
			check(rx, 16'h0000);
			check(chan, k[2:0]);
			check({refDisable, pm}, cfg[2:0]);
		end
	endtask
	// Too few rises must leave every field as it was
	task t_abort;
		host.frame(8'h00, 4, rx);
		check({chan, refDisable, pm}, cfg[5:0]);
	endtask
	task t_fill_drain;
		for (int k = 0; k < 16; k++) begin
			resData = code(k);
			resValid = 1'h1;
			@(negedge ref_clk);
		end
		resData = 12'hfff;
		for (int w = 0; w < 4 && resReady === 1'h1; w++) @(negedge ref_clk);
		check(resReady, 16'h0000);
		resValid = 1'h0;
		host.wake;
		for (int k = 0; k < 16; k++) begin
			host.frame(8'h00, 16, rx);
			check(rx, {4'h0, code(k)});
		end
		check(resReady, 16'h0001);
	endtask
	initial begin
		repeat (60000) @(posedge ref_clk);
		nMismatch++;
		tally_and_finish;
	end
	initial begin
		t_reset;
		t_channels;
		t_abort;
		t_fill_drain;
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
